// >>> common/uart_ctl_pkg.sv
package uart_ctl_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] DIV_LOW_OFFSET = 12'h0_000;
  localparam logic [11:0] DIV_HIGH_OFFSET = 12'h0_004;
  localparam logic [11:0] POWER_DEBUG_CONTROL_OFFSET = 12'h0_008;
  localparam logic [11:0] OVERSAMPLE_MODE_OFFSET = 12'h0_00C;
  localparam logic [11:0] RUN_STATUS_OFFSET = 12'h0_010;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TX_ENABLE_BIT = 14;
  localparam int RX_ENABLE_BIT = 13;
  localparam int RUN_THROUGH_BIT = 0;
  localparam int SAMPLING_RATIO_BIT = 0;
  localparam int RESV_ONES_LSB = 1;
  localparam int RESV_ONES_MSB = 12;

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [31:0] RESV_ONES_MASK = 32'h0000_1FFE;
  localparam logic [7:0] DIV_BYTE_RESET = 8'h00;
  localparam logic [4:0] OVERSAMPLE_16 = 5'h10;
  localparam logic [4:0] OVERSAMPLE_13 = 5'h0D;
  localparam logic [1:0] DIV_WRITE_WAIT = 2'h2;

  typedef enum logic [1:0] {
    RUNNING,
    DRAINING,
    HALTED
  } halt_state_type;

endpackage

// >>> dv/debug_halt_model.sv
`timescale 1ns/1ps
module debug_halt_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic haltCmd,
  input wire logic slow,
  output logic haltRequest
);
  logic [3:0] delay_q, delay_d;
  always_comb delay_d = {delay_q[2:0], haltCmd};
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) delay_q <= 4'h0;
    else delay_q <= delay_d;
  // Single request level.
  // A slow request lets a word get under way before the halt lands.
  assign haltRequest = slow ? delay_q[3] : delay_q[0];
endmodule

// >>> dv/uart_ctl_checker_assertions.sv
`timescale 1ns/1ps
module uart_ctl_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic haltRequest,
  input wire logic txWordActive,
  input wire logic interruptRequest,
  input wire logic txResetN,
  input wire logic txRun,
  input wire logic interruptOut,
  input wire logic [15:0] baudDivisor,
  input wire logic debugHalted
);
  logic freeRun_q, freeRun_d;
  // The run-through bit is not a port, so it is shadowed from writes.
  always_comb freeRun_d = (psel && penable && pready && pwrite &&
    paddr == uart_ctl_pkg::POWER_DEBUG_CONTROL_OFFSET) ?
    pwdata[uart_ctl_pkg::RUN_THROUGH_BIT] : freeRun_q;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) freeRun_q <= 1'b0;
    else freeRun_q <= freeRun_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence divSetup;
    psel && !penable && pwrite &&
    (paddr == uart_ctl_pkg::DIV_LOW_OFFSET ||
     paddr == uart_ctl_pkg::DIV_HIGH_OFFSET);
  endsequence
  sequence twoWaits; !pready [*2] ##1 pready; endsequence
  sequence lowDone; psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  a_div_wait: assert property (divSetup |=> twoWaits)
    else $error("Wait states wrong.");
  a_div_low: assert property (lowDone |-> ##2
    baudDivisor[7:0] == $past(pwdata[7:0], 2)) else $error("Low byte lost.");
  a_tx_gate: assert property (txRun == (txResetN && !debugHalted))
    else $error("Tx run wrong.");
  a_irq_gate: assert property (
    interruptOut == (interruptRequest && !debugHalted)) else $error("Irq.");
  a_halt_idle: assert property (haltRequest && !freeRun_q &&
    !txWordActive |=> debugHalted) else $error("No prompt halt.");
  a_drain_hold: assert property (txWordActive && !debugHalted
    |=> !debugHalted) else $error("Halted mid word.");
  a_free_run: assert property (freeRun_q |=> !debugHalted)
    else $error("Halted in run-through.");
  a_halt_release: assert property (!haltRequest |=> !debugHalted)
    else $error("Halt outlived request.");
endmodule
bind uart_run_and_oversample_ctl uart_ctl_checker u_uart_ctl_checker (
  .clk(clk),
  .rstn(rstn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .haltRequest(haltRequest),
  .txWordActive(txWordActive),
  .interruptRequest(interruptRequest),
  .txResetN(txResetN),
  .txRun(txRun),
  .interruptOut(interruptOut),
  .baudDivisor(baudDivisor),
  .debugHalted(debugHalted)
);

// >>> dv/uart_run_and_oversample_ctl_test.sv
`timescale 1ns/1ps
module uart_run_and_oversample_ctl_test;
  localparam logic [11:0] CTL = uart_ctl_pkg::POWER_DEBUG_CONTROL_OFFSET;
  localparam logic [11:0] MODE = uart_ctl_pkg::OVERSAMPLE_MODE_OFFSET;
  localparam logic [11:0] LOW_ADDR = uart_ctl_pkg::DIV_LOW_OFFSET;
  localparam logic [11:0] HIGH_ADDR = uart_ctl_pkg::DIV_HIGH_OFFSET;
  localparam logic [11:0] STAT = uart_ctl_pkg::RUN_STATUS_OFFSET;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, haltCmd = 1'b0, slow = 1'b0, dmaRequest = 1'b0;
  logic txWordActive = 1'b0, interruptRequest = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, haltRequest, txResetN, rxResetN, err;
  logic txRun, rxRun, interruptOut, dmaOut, debugHalted;
  logic [4:0] oversampleRatio;
  logic [15:0] baudDivisor;
  int fail_count = 0, total_checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  uart_run_and_oversample_ctl u_uart_run_and_oversample_ctl (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .haltRequest(haltRequest),
    .txWordActive(txWordActive),
    .interruptRequest(interruptRequest),
    .dmaRequest(dmaRequest),
    .txResetN(txResetN),
    .rxResetN(rxResetN),
    .txRun(txRun),
    .rxRun(rxRun),
    .interruptOut(interruptOut),
    .dmaOut(dmaOut),
    .oversampleRatio(oversampleRatio),
    .baudDivisor(baudDivisor),
    .debugHalted(debugHalted)
  );
  debug_halt_model u_debug_halt_model (
    .clk(clk),
    .rstn(rstn),
    .haltCmd(haltCmd),
    .slow(slow),
    .haltRequest(haltRequest)
  );
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    // Read data and the error flag are taken at the completing edge.
    @(posedge clk);
    err = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  // A bounded wait, so that a late halt or release is a mismatch.
  task automatic waitHalt(input logic exp, input int lim);
    int n;
    n = 0;
    while (debugHalted !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(debugHalted, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(CTL, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_1FFE);
    chk({txResetN, rxResetN}, 2'h0);
    chk(oversampleRatio, 5'h10);
    chk(baudDivisor, 16'h0000);
    $display("Test reset done");
    apb(CTL, 1'b1, 32'h0000_4000);
    chk({txRun, rxRun, txResetN, rxResetN}, 4'hA);
    apb(CTL, 1'b1, 32'h0000_2000);
    chk({txRun, rxRun, txResetN, rxResetN}, 4'h5);
    apb(CTL, 1'b1, 32'h0000_6000);
    apb(CTL, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_7FFE);
    apb(MODE, 1'b1, 32'h0000_0001);
    chk(oversampleRatio, 5'h0D);
    apb(MODE, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_0001);
    apb(MODE, 1'b1, 32'h0000_0000);
    chk(oversampleRatio, 5'h10);
    apb(LOW_ADDR, 1'b1, 32'h0000_00AB);
    apb(HIGH_ADDR, 1'b1, 32'h0000_00CD);
    // The combined divisor follows the byte latches one clock later.
    @(negedge clk);
    chk(baudDivisor, 16'hCDAB);
    apb(HIGH_ADDR, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_00CD);
    apb(12'h020, 1'b0, 32'h0000_0000);
    chk({err, rdata[30:0]}, 32'h8000_0000);
    $display("Test registers done");
    @(posedge clk);
    interruptRequest <= 1'b1;
    dmaRequest <= 1'b1;
    haltCmd <= 1'b1;
    waitHalt(1'b1, 3);
    chk({interruptOut, dmaOut, txRun, rxRun}, 4'h0);
    apb(CTL, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_7FFE);
    @(posedge clk);
    haltCmd <= 1'b0;
    waitHalt(1'b0, 3);
    chk({interruptOut, dmaOut}, 2'h3);
    $display("Test halt done");
    // Let the model's delay line empty before it switches to the late tap.
    repeat (4) @(posedge clk);
    slow <= 1'b1;
    txWordActive <= 1'b1;
    haltCmd <= 1'b1;
    repeat (8) @(negedge clk);
    chk({debugHalted, txRun, rxRun}, 3'h2);
    apb(STAT, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_0006);
    @(posedge clk);
    txWordActive <= 1'b0;
    waitHalt(1'b1, 2);
    @(posedge clk);
    haltCmd <= 1'b0;
    waitHalt(1'b0, 6);
    $display("Test drain done");
    apb(CTL, 1'b1, 32'h0000_6001);
    @(posedge clk);
    haltCmd <= 1'b1;
    repeat (8) @(negedge clk);
    chk({debugHalted, interruptOut}, 2'h1);
    apb(CTL, 1'b1, 32'h0000_6000);
    waitHalt(1'b1, 2);
    $display("Test run-through done");
    complete_run();
  end
endmodule

// >>> hdl/halt_sequencer.sv
`timescale 1ns/1ps
module halt_sequencer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic haltRequest,
  input wire logic runThrough,
  input wire logic txWordActive,
  output logic halted,
  output logic draining
);

  uart_ctl_pkg::halt_state_type state_q;
  uart_ctl_pkg::halt_state_type state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uart_ctl_pkg::RUNNING: begin
        // [R8] Run-through ignores halt.
        if (haltRequest && !runThrough) begin
          // [R6] Idle halts at once.
          // [R7] Busy finishes word.
          state_d = txWordActive ? uart_ctl_pkg::DRAINING
                                 : uart_ctl_pkg::HALTED;
        end
      end
      uart_ctl_pkg::DRAINING: begin
        // [R11] Dropped request resumes.
        if (!haltRequest || runThrough) begin
          state_d = uart_ctl_pkg::RUNNING;
        end else if (!txWordActive) begin
          state_d = uart_ctl_pkg::HALTED;
        end
      end
      uart_ctl_pkg::HALTED: begin
        // [R11] Run-through releases halt.
        if (!haltRequest || runThrough) begin
          state_d = uart_ctl_pkg::RUNNING;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= uart_ctl_pkg::RUNNING;
    end else begin
      state_q <= state_d;
    end
  end

  assign halted = (state_q == uart_ctl_pkg::HALTED);
  assign draining = (state_q == uart_ctl_pkg::DRAINING);

endmodule

// >>> hdl/uart_run_and_oversample_ctl.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Software always writes zero to control bit 15.
// [R2] Transmitter enable bit 14 low holds the transmitter in reset.
// [R3] Receiver enable bit 13 low holds the receiver in reset.
// [R4] Control bit 0 picks the reaction to a debug halt.
// [R5] When halted, registers still work; no transfer, interrupt or DMA.
// [R6] Run-through clear and idle transmitter: halt immediately.
// [R7] Run-through clear and word in flight: finish word, then halt.
// [R8] Run-through set: debug halts are ignored.
// [R9] Mode bit 0 selects 16x (zero) or 13x (one) oversampling.
// [R10] Divisor is sixteen bits built from high and low byte latches.
// [R11] One halt request input; run-through matters only while asserted.
module uart_run_and_oversample_ctl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltRequest,
  input wire logic txWordActive,
  input wire logic interruptRequest,
  input wire logic dmaRequest,
  output logic txResetN,
  output logic rxResetN,
  output logic txRun,
  output logic rxRun,
  output logic interruptOut,
  output logic dmaOut,
  output logic [4:0] oversampleRatio,
  output logic [15:0] baudDivisor,
  output logic debugHalted
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rstSync1_q;
  logic rstSync2_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  logic rstLocalN;
  assign rstLocalN = rstSync2_q;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic txEnable_q;
  logic txEnable_d;
  logic rxEnable_q;
  logic rxEnable_d;
  logic runThrough_q;
  logic runThrough_d;
  logic ratioSelect_q;
  logic ratioSelect_d;
  logic [7:0] divLow_q;
  logic [7:0] divLow_d;
  logic [7:0] divHigh_q;
  logic [7:0] divHigh_d;
  logic [1:0] waitCount_q;
  logic [1:0] waitCount_d;
  logic [15:0] baudDivisor_q;
  logic [15:0] baudDivisor_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  logic halted;
  logic draining;

  function automatic logic isDivisor(input logic [11:0] addr);
    isDivisor = (addr == uart_ctl_pkg::DIV_LOW_OFFSET) ||
                (addr == uart_ctl_pkg::DIV_HIGH_OFFSET);
  endfunction

  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = isDivisor(addr) ||
               (addr == uart_ctl_pkg::POWER_DEBUG_CONTROL_OFFSET) ||
               (addr == uart_ctl_pkg::OVERSAMPLE_MODE_OFFSET) ||
               (addr == uart_ctl_pkg::RUN_STATUS_OFFSET);
  endfunction

  logic access;
  logic divWrite;
  logic done;

  assign access = psel && penable;
  assign divWrite = access && pwrite && isDivisor(paddr);
  // Divisor writes stretch by two wait states while the generator loads.
  assign done = access &&
                (!divWrite || waitCount_q == uart_ctl_pkg::DIV_WRITE_WAIT);

  // [R5] Bus always served.
  assign pready = done;
  assign pslverr = done && !isMapped(paddr);

  always_comb begin
    txEnable_d = txEnable_q;
    rxEnable_d = rxEnable_q;
    runThrough_d = runThrough_q;
    ratioSelect_d = ratioSelect_q;
    divLow_d = divLow_q;
    divHigh_d = divHigh_q;
    prdata_d = prdata_q;
    waitCount_d = 2'h0;
    if (divWrite && !done) begin
      waitCount_d = waitCount_q + 2'h1;
    end
    // [R10] Divisor load.
    baudDivisor_d = {divHigh_q, divLow_q};
    if (done && pwrite) begin
      unique case (paddr)
        uart_ctl_pkg::DIV_LOW_OFFSET: divLow_d = pwdata[7:0];
        uart_ctl_pkg::DIV_HIGH_OFFSET: divHigh_d = pwdata[7:0];
        uart_ctl_pkg::POWER_DEBUG_CONTROL_OFFSET: begin
          // Bit 15 is not stored, so a stray one cannot stick.
          // [R2] Transmitter enable write.
          txEnable_d = pwdata[uart_ctl_pkg::TX_ENABLE_BIT];
          // [R3] Receiver enable write.
          rxEnable_d = pwdata[uart_ctl_pkg::RX_ENABLE_BIT];
          // [R4] Halt mode write.
          runThrough_d = pwdata[uart_ctl_pkg::RUN_THROUGH_BIT];
        end
        uart_ctl_pkg::OVERSAMPLE_MODE_OFFSET: begin
          ratioSelect_d = pwdata[uart_ctl_pkg::SAMPLING_RATIO_BIT];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in the setup cycle so that it already stands
    // when pready rises; status bits are therefore one cycle old.
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        uart_ctl_pkg::DIV_LOW_OFFSET: prdata_d[7:0] = divLow_q;
        uart_ctl_pkg::DIV_HIGH_OFFSET: prdata_d[7:0] = divHigh_q;
        uart_ctl_pkg::POWER_DEBUG_CONTROL_OFFSET: begin
          prdata_d = uart_ctl_pkg::RESV_ONES_MASK;
          prdata_d[uart_ctl_pkg::TX_ENABLE_BIT] = txEnable_q;
          prdata_d[uart_ctl_pkg::RX_ENABLE_BIT] = rxEnable_q;
          prdata_d[uart_ctl_pkg::RUN_THROUGH_BIT] = runThrough_q;
        end
        uart_ctl_pkg::OVERSAMPLE_MODE_OFFSET: begin
          prdata_d[uart_ctl_pkg::SAMPLING_RATIO_BIT] = ratioSelect_q;
        end
        uart_ctl_pkg::RUN_STATUS_OFFSET: begin
          prdata_d[0] = halted;
          prdata_d[1] = draining;
          prdata_d[2] = haltRequest;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      txEnable_q <= 1'b0;
      rxEnable_q <= 1'b0;
      runThrough_q <= 1'b0;
      ratioSelect_q <= 1'b0;
      divLow_q <= uart_ctl_pkg::DIV_BYTE_RESET;
      divHigh_q <= uart_ctl_pkg::DIV_BYTE_RESET;
      waitCount_q <= 2'h0;
      baudDivisor_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
    end else begin
      txEnable_q <= txEnable_d;
      rxEnable_q <= rxEnable_d;
      runThrough_q <= runThrough_d;
      ratioSelect_q <= ratioSelect_d;
      divLow_q <= divLow_d;
      divHigh_q <= divHigh_d;
      waitCount_q <= waitCount_d;
      baudDivisor_q <= baudDivisor_d;
      prdata_q <= prdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Debug halt handling
  // ---------------------------------------------------------------
  halt_sequencer haltSeq (
    .clk(clk),
    .rstn(rstLocalN),
    .haltRequest(haltRequest),
    .runThrough(runThrough_q),
    .txWordActive(txWordActive),
    .halted(halted),
    .draining(draining)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign baudDivisor = baudDivisor_q;
  assign debugHalted = halted;
  // [R2] Transmitter held reset.
  assign txResetN = txEnable_q;
  // [R3] Receiver held reset.
  assign rxResetN = rxEnable_q;
  // [R5] Halt stops traffic.
  // Draining keeps the transmitter running to finish its word, but the
  // receiver stops at once so no new word is taken in.
  assign txRun = txEnable_q && !halted;
  assign rxRun = rxEnable_q && !halted && !draining;
  // [R5] Events masked when halted.
  assign interruptOut = interruptRequest && !halted;
  assign dmaOut = dmaRequest && !halted;
  // [R9] Oversampling ratio.
  assign oversampleRatio = ratioSelect_q ? uart_ctl_pkg::OVERSAMPLE_13
                                         : uart_ctl_pkg::OVERSAMPLE_16;

endmodule
